/* File: verilog/scip_cpu.sv */
// Processor end: control-pin sequencing for NMI, soft reset, management mode, halt and hold
module scip_cpu
	import scip_pkg::*;
(
	input wire logic ref_clk,
	input wire logic resetn,
	scip_if.cpu pins,
	input wire logic instr_boundary,
	input wire logic rep_iteration,
	input wire logic locked_seq,
	input wire logic bus_cycle_busy,
	input wire logic bus_req_core,
	input wire logic drained,
	input wire logic resume_from_mgmt_instr,
	input wire logic save_done,
	input wire logic restore_done,
	input wire logic nmi_take,
	input wire logic [31:0] base_wdata,
	input wire logic base_we,
	output logic nmi_pending,
	output logic soft_reset_pulse,
	output logic core_stopped,
	output logic in_mgmt,
	output logic [31:0] mgmt_base_reg
);
	// Synchroniser stages: first stage is read only by the second
	logic [3:0] sync1_reg, sync1_next;
	logic [3:0] sync2_reg, sync2_next;
	logic [3:0] sync3_reg, sync3_next;
	// Pending flags for NMI and management irq, edge history for soft reset
	logic nmi_pend_reg, nmi_pend_next;
	logic smi_pend_reg, smi_pend_next;
	logic srst_prev_reg, srst_prev_next;
	logic srst_pulse_reg, srst_pulse_next;
	scip_core_t core_reg, core_next;
	scip_bus_t bus_reg, bus_next;
	logic active_n_reg, active_n_next;
	logic grant_reg, grant_next;
	logic want_reg, want_next;
	logic ack_reg, ack_next;
	logic float_reg, float_next;
	logic [31:0] base_reg, base_next;
	// Registered status copies so these outputs come straight from flops
	logic stopped_reg, stopped_next;
	logic mgmt_reg, mgmt_next;
	// Synchronised levels: 0 nmi, 1 soft reset, 2 mgmt irq, 3 halt
	logic nmi_s, srst_s, smi_n_s, halt_n_s;
	logic nmi_rise, smi_fall, at_boundary, srst_active;

	// Input synchroniser next values
	always_comb begin
		sync1_next = {~pins.clock_halt_req_n, ~pins.sys_mgmt_irq_n,
			pins.soft_restart_in, pins.nmi};
		sync2_next = sync1_reg;
		sync3_next = sync2_reg;
	end

	// Synchroniser registers; idle levels after reset
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			sync1_reg <= 4'h0;
			sync2_reg <= 4'h0;
			sync3_reg <= 4'h0;
		end else begin
			sync1_reg <= sync1_next;
			sync2_reg <= sync2_next;
			sync3_reg <= sync3_next;
		end
	end

	// Decoded edges, taken from the second stage and its delayed copy only
	always_comb begin
		nmi_s = sync2_reg[0];
		srst_s = sync2_reg[1];
		smi_n_s = ~sync2_reg[2];
		halt_n_s = ~sync2_reg[3];
		nmi_rise = nmi_s & ~sync3_reg[0];
		smi_fall = ~smi_n_s & ~sync3_reg[2];
		at_boundary = instr_boundary | rep_iteration;
		srst_active = srst_s;
	end

	// Next state of the sequencers and pins
	always_comb begin
		nmi_pend_next = nmi_pend_reg;
		smi_pend_next = smi_pend_reg;
		srst_prev_next = srst_s;
		srst_pulse_next = 1'b0;
		core_next = core_reg;
		bus_next = bus_reg;
		active_n_next = active_n_reg;
		grant_next = 1'b0;
		want_next = bus_req_core;
		ack_next = ack_reg;
		float_next = float_reg;
		base_next = base_reg;
		if (nmi_take)
			nmi_pend_next = 1'b0;
		if (nmi_rise)
			nmi_pend_next = 1'b1;
		if (smi_fall)
			smi_pend_next = 1'b1;
		if (base_we)
			base_next = base_wdata;
		case (core_reg)
			SCIP_RUN: begin
				if (smi_pend_reg && at_boundary && !locked_seq) begin
					core_next = SCIP_SAVE;
					active_n_next = 1'b0;
					smi_pend_next = smi_fall;
				end else if (!halt_n_s && instr_boundary && !nmi_pend_reg) begin
					core_next = SCIP_DRAIN;
				end
			end
			SCIP_SAVE: begin
				// State save cycles run to completion
				if (save_done)
					core_next = SCIP_MGMT;
			end
			SCIP_MGMT: begin
				if (resume_from_mgmt_instr)
					core_next = SCIP_RESTORE;
			end
			SCIP_RESTORE: begin
				if (restore_done) begin
					core_next = SCIP_RUN;
					active_n_next = 1'b1;
				end
			end
			SCIP_DRAIN: begin
				if (drained && !bus_cycle_busy && bus_reg == SCIP_BUS_OWN) begin
					core_next = SCIP_GRANT;
					grant_next = 1'b1;
				end
			end
			SCIP_GRANT: begin
				// One-clock stop grant cycle done
				core_next = SCIP_STOPPED;
			end
			SCIP_STOPPED: begin
				if (halt_n_s)
					core_next = SCIP_RUN;
			end
			default: begin
				core_next = SCIP_RUN;
			end
		endcase
		case (bus_reg)
			SCIP_BUS_OWN: begin
				if (pins.hold_req)
					bus_next = SCIP_BUS_WAIT;
			end
			SCIP_BUS_WAIT: begin
				if (!pins.hold_req) begin
					bus_next = SCIP_BUS_OWN;
				end else if (!bus_cycle_busy && !locked_seq && !grant_next) begin
					bus_next = SCIP_BUS_HOLD;
					ack_next = 1'b1;
					float_next = 1'b1;
				end
			end
			SCIP_BUS_HOLD: begin
				if (!pins.hold_req) begin
					bus_next = SCIP_BUS_OWN;
					ack_next = 1'b0;
					float_next = 1'b0;
				end
			end
			default: begin
				bus_next = SCIP_BUS_OWN;
			end
		endcase
		if (srst_active) begin
			srst_pulse_next = ~srst_prev_reg;
			nmi_pend_next = 1'b0;
			smi_pend_next = 1'b0;
			core_next = SCIP_RUN;
			bus_next = SCIP_BUS_OWN;
			active_n_next = 1'b1;
			grant_next = 1'b0;
			ack_next = 1'b0;
			float_next = 1'b0;
			base_next = base_reg;
		end
		// Status follows the next state so it lines up with the pins
		stopped_next = (core_next == SCIP_STOPPED);
		mgmt_next = ~active_n_next;
	end

	// Sequencer registers; hard reset also restores the base
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			nmi_pend_reg <= 1'b0;
			smi_pend_reg <= 1'b0;
			srst_prev_reg <= 1'b0;
			srst_pulse_reg <= 1'b0;
			core_reg <= SCIP_RUN;
			bus_reg <= SCIP_BUS_OWN;
			active_n_reg <= 1'b1;
			grant_reg <= 1'b0;
			want_reg <= 1'b0;
			ack_reg <= 1'b0;
			float_reg <= 1'b0;
			base_reg <= SCIP_BASE_RST;
			stopped_reg <= 1'b0;
			mgmt_reg <= 1'b0;
		end else begin
			nmi_pend_reg <= nmi_pend_next;
			smi_pend_reg <= smi_pend_next;
			srst_prev_reg <= srst_prev_next;
			srst_pulse_reg <= srst_pulse_next;
			core_reg <= core_next;
			bus_reg <= bus_next;
			active_n_reg <= active_n_next;
			grant_reg <= grant_next;
			want_reg <= want_next;
			ack_reg <= ack_next;
			float_reg <= float_next;
			base_reg <= base_next;
			stopped_reg <= stopped_next;
			mgmt_reg <= mgmt_next;
		end
	end

	assign pins.internal_bus_want = want_reg;
	assign pins.mgmt_active_n = active_n_reg;
	assign pins.stop_grant = grant_reg;
	assign pins.bus_yield_ack = ack_reg;
	assign pins.bus_float = float_reg;
	assign nmi_pending = nmi_pend_reg;
	assign soft_reset_pulse = srst_pulse_reg;
	assign core_stopped = stopped_reg;
	assign in_mgmt = mgmt_reg;
	assign mgmt_base_reg = base_reg;
endmodule

/* File: verilog/scip_pkg.sv */
// Package with the constants and types shared by both ends of the control-pin link
package scip_pkg;
	// Least low time of the NMI pin before its rising edge, in clocks
	localparam int unsigned SCIP_NMI_LOW_CLKS = 4;
	// Least soft reset assertion, in clocks
	localparam int unsigned SCIP_SRST_CLKS = 15;
	// Width of the management base register
	localparam int unsigned SCIP_BASE_W = 32;
	// Reset value of the management base register (arbitrary default)
	localparam logic [31:0] SCIP_BASE_RST = 32'h0003_0000;
	// Width of the clock counters on the system side
	localparam int unsigned SCIP_CNT_W = 5;
	// Core sequencer states
	typedef enum logic [2:0] {
		SCIP_RUN,
		SCIP_SAVE,
		SCIP_MGMT,
		SCIP_RESTORE,
		SCIP_DRAIN,
		SCIP_GRANT,
		SCIP_STOPPED
	} scip_core_t;
	// Bus arbitration states
	typedef enum logic [1:0] {
		SCIP_BUS_OWN,
		SCIP_BUS_WAIT,
		SCIP_BUS_HOLD
	} scip_bus_t;
endpackage

/* File: verilog/scip_if.sv */
// Interface carrying the control pins between the processor and the system logic
interface scip_if;
	logic nmi;
	logic soft_restart_in;
	logic sys_mgmt_irq_n;
	logic mgmt_active_n;
	logic clock_halt_req_n;
	logic stop_grant;
	logic internal_bus_want;
	logic hold_req;
	logic bus_yield_ack;
	logic bus_float;
	// Processor end
	modport cpu (
		input nmi,
		input soft_restart_in,
		input sys_mgmt_irq_n,
		input clock_halt_req_n,
		input hold_req,
		output mgmt_active_n,
		output stop_grant,
		output internal_bus_want,
		output bus_yield_ack,
		output bus_float
	);
	// System logic end
	modport sys (
		output nmi,
		output soft_restart_in,
		output sys_mgmt_irq_n,
		output clock_halt_req_n,
		output hold_req,
		input mgmt_active_n,
		input stop_grant,
		input internal_bus_want,
		input bus_yield_ack,
		input bus_float
	);
endinterface

/* File: verilog/scip_sys.sv */
// System end: drives the control pins with the minimum low and hold times
module scip_sys
	import scip_pkg::*;
(
	input wire logic ref_clk,
	input wire logic resetn,
	scip_if.sys pins,
	input wire logic nmi_fire,
	input wire logic srst_fire,
	input wire logic smi_fire,
	input wire logic halt_want,
	input wire logic hold_want,
	output logic halt_granted,
	output logic hold_granted,
	output logic cpu_in_mgmt,
	output logic cpu_bus_want
);
	logic [SCIP_CNT_W-1:0] nmi_cnt_reg, nmi_cnt_next;
	logic [SCIP_CNT_W-1:0] srst_cnt_reg, srst_cnt_next;
	logic nmi_reg, nmi_next;
	logic smi_n_reg, smi_n_next;
	logic halt_n_reg, halt_n_next;
	logic granted_reg, granted_next;
	logic hold_reg, hold_next;
	logic hgrant_reg, hgrant_next;
	logic mgmt_reg, mgmt_next;
	logic want_reg, want_next;

	// Pin sequencing next values
	always_comb begin
		nmi_cnt_next = nmi_cnt_reg;
		srst_cnt_next = srst_cnt_reg;
		nmi_next = nmi_reg;
		smi_n_next = ~smi_fire;
		halt_n_next = halt_n_reg;
		granted_next = granted_reg;
		hold_next = hold_want;
		hgrant_next = pins.bus_yield_ack;
		mgmt_next = ~pins.mgmt_active_n;
		want_next = pins.internal_bus_want;
		if (nmi_reg) begin
			nmi_next = 1'b0;
			nmi_cnt_next = '0;
		end else if (nmi_cnt_reg < SCIP_CNT_W'(SCIP_NMI_LOW_CLKS)) begin
			nmi_cnt_next = nmi_cnt_reg + 1'b1;
		end else if (nmi_fire) begin
			nmi_next = 1'b1;
		end
		if (srst_fire)
			srst_cnt_next = SCIP_CNT_W'(SCIP_SRST_CLKS);
		else if (srst_cnt_reg != '0)
			srst_cnt_next = srst_cnt_reg - 1'b1;
		if (halt_want)
			halt_n_next = 1'b0;
		if (pins.stop_grant)
			granted_next = 1'b1;
		if (!halt_want && (granted_reg || halt_n_reg)) begin
			halt_n_next = 1'b1;
			granted_next = 1'b0;
		end
	end

	// Pin registers with idle levels after reset
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			nmi_cnt_reg <= '0;
			srst_cnt_reg <= '0;
			nmi_reg <= 1'b0;
			smi_n_reg <= 1'b1;
			halt_n_reg <= 1'b1;
			granted_reg <= 1'b0;
			hold_reg <= 1'b0;
			hgrant_reg <= 1'b0;
			mgmt_reg <= 1'b0;
			want_reg <= 1'b0;
		end else begin
			nmi_cnt_reg <= nmi_cnt_next;
			srst_cnt_reg <= srst_cnt_next;
			nmi_reg <= nmi_next;
			smi_n_reg <= smi_n_next;
			halt_n_reg <= halt_n_next;
			granted_reg <= granted_next;
			hold_reg <= hold_next;
			hgrant_reg <= hgrant_next;
			mgmt_reg <= mgmt_next;
			want_reg <= want_next;
		end
	end

	assign pins.nmi = nmi_reg;
	assign pins.soft_restart_in = (srst_cnt_reg != '0);
	assign pins.sys_mgmt_irq_n = smi_n_reg;
	assign pins.clock_halt_req_n = halt_n_reg;
	assign pins.hold_req = hold_reg;
	assign halt_granted = granted_reg;
	assign hold_granted = hgrant_reg;
	assign cpu_in_mgmt = mgmt_reg;
	assign cpu_bus_want = want_reg;
endmodule

/* File: sim/scip_sva.sv */
// Checker watching the control-pin link between the two ends
module scip_sva (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic nmi,
	input wire logic soft_restart_in,
	input wire logic sys_mgmt_irq_n,
	input wire logic mgmt_active_n,
	input wire logic clock_halt_req_n,
	input wire logic stop_grant,
	input wire logic internal_bus_want,
	input wire logic hold_req,
	input wire logic bus_yield_ack,
	input wire logic bus_float
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	// Clocks the soft reset has stayed high; saturates so it never wraps
	logic [4:0] srst_cnt_reg;
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			srst_cnt_reg <= 5'h00;
		end else if (!soft_restart_in) begin
			srst_cnt_reg <= 5'h00;
		end else if (srst_cnt_reg != 5'h1F) begin
			srst_cnt_reg <= srst_cnt_reg + 5'h01;
		end
	end
	property p_nmi_low;
		$rose(nmi) |-> !$past(nmi, 2) && !$past(nmi, 3) && !$past(nmi, 4);
	endproperty
	a_nmi_low: assert property (p_nmi_low) else $error("nmi low time short");
	property p_srst_len;
		$fell(soft_restart_in) |-> srst_cnt_reg >= 5'h0F;
	endproperty
	a_srst_len: assert property (p_srst_len) else $error("soft reset short");
	property p_smi_enter;
		$fell(sys_mgmt_irq_n) |-> ##[1:200] !mgmt_active_n;
	endproperty
	a_smi_enter: assert property (p_smi_enter) else $error("no management entry");
	property p_grant;
		stop_grant |-> !clock_halt_req_n && !$past(clock_halt_req_n, 3);
	endproperty
	a_grant: assert property (p_grant) else $error("grant without request");
	property p_ack_rise;
		$rose(bus_yield_ack) |-> hold_req && $past(hold_req, 2);
	endproperty
	a_ack_rise: assert property (p_ack_rise) else $error("ack too early");
	property p_ack_float;
		bus_yield_ack == bus_float;
	endproperty
	a_ack_float: assert property (p_ack_float) else $error("ack and float differ");
	property p_ack_hold;
		bus_yield_ack && hold_req |=> bus_yield_ack;
	endproperty
	a_ack_hold: assert property (p_ack_hold) else $error("hold left early");
	property p_ack_drop;
		bus_yield_ack && !hold_req |=> !bus_yield_ack && !bus_float;
	endproperty
	a_ack_drop: assert property (p_ack_drop) else $error("hold not left");
endmodule

/* File: sim/cpu_system_control_inputs_tb.sv */
// Testbench joining the processor end and the system end
module cpu_system_control_inputs_tb;
	import scip_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;
	logic ref_clk, resetn, instr_boundary, rep_iteration, locked_seq, bus_cycle_busy;
	logic bus_req_core, drained, resume_from_mgmt_instr, save_done, restore_done;
	logic nmi_take, base_we, nmi_pending, soft_reset_pulse, core_stopped, in_mgmt;
	logic [31:0] base_wdata;
	logic [31:0] mgmt_base_reg;
	logic nmi_fire, srst_fire, smi_fire, halt_want, hold_want;
	logic halt_granted, hold_granted, cpu_in_mgmt, cpu_bus_want;
	int error_cnt = 0;
	int compares = 0;
	int cyc = 0;
	int n;
	scip_if link();
	scip_cpu scip_cpu_inst (.ref_clk(ref_clk), .resetn(resetn), .pins(link),
		.instr_boundary(instr_boundary), .rep_iteration(rep_iteration),
		.locked_seq(locked_seq), .bus_cycle_busy(bus_cycle_busy),
		.bus_req_core(bus_req_core), .drained(drained),
		.resume_from_mgmt_instr(resume_from_mgmt_instr), .save_done(save_done),
		.restore_done(restore_done), .nmi_take(nmi_take), .base_wdata(base_wdata),
		.base_we(base_we), .nmi_pending(nmi_pending), .soft_reset_pulse(soft_reset_pulse),
		.core_stopped(core_stopped), .in_mgmt(in_mgmt), .mgmt_base_reg(mgmt_base_reg));
	scip_sys scip_sys_inst (.ref_clk(ref_clk), .resetn(resetn), .pins(link),
		.nmi_fire(nmi_fire), .srst_fire(srst_fire), .smi_fire(smi_fire),
		.halt_want(halt_want), .hold_want(hold_want), .halt_granted(halt_granted),
		.hold_granted(hold_granted), .cpu_in_mgmt(cpu_in_mgmt), .cpu_bus_want(cpu_bus_want));
	scip_sva scip_sva_inst (.ref_clk(ref_clk), .resetn(resetn), .nmi(link.nmi),
		.soft_restart_in(link.soft_restart_in), .sys_mgmt_irq_n(link.sys_mgmt_irq_n),
		.mgmt_active_n(link.mgmt_active_n), .clock_halt_req_n(link.clock_halt_req_n),
		.stop_grant(link.stop_grant), .internal_bus_want(link.internal_bus_want),
		.hold_req(link.hold_req), .bus_yield_ack(link.bus_yield_ack),
		.bus_float(link.bus_float));
	// Free-running 250 MHz clock
	always #2 ref_clk = ~ref_clk;
	// Inputs move just after the edge so sampling never races
	task automatic step(input int k);
		repeat (k) @(posedge ref_clk);
		#1;
	endtask
	task automatic pulse(ref logic s);
		s = 1'b1;
		step(1);
		s = 1'b0;
	endtask
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic end_of_test();
		$display("Compares %0d mismatches %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// Cuts a hang short; the tests need a few hundred cycles
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc > 3000) begin
			error_cnt++;
			$display("ERROR timeout expected end seen %0d cycles", cyc);
			end_of_test();
		end
	end
	initial begin
		ref_clk = 1'b0;
		{instr_boundary, rep_iteration, locked_seq, bus_cycle_busy, bus_req_core} = '0;
		{drained, resume_from_mgmt_instr, save_done, restore_done, nmi_take, base_we} = '0;
		{nmi_fire, srst_fire, smi_fire, halt_want, hold_want} = '0;
		base_wdata = 32'h0000_0000;
		resetn = 1'b0;
		step(6);
		resetn = 1'b1;
		step(8);
		chk("base", SCIP_BASE_RST, mgmt_base_reg);
		chk("active", 1'b1, link.mgmt_active_n);
		// Edge-triggered interrupt stays pending until taken
		pulse(nmi_fire);
		step(12);
		chk("nmi_pending", 1'b1, nmi_pending);
		pulse(nmi_take);
		step(1);
		chk("nmi_taken", 1'b0, nmi_pending);
		$display("Test nmi done");
		// Management entry waits for an unlocked boundary
		pulse(smi_fire);
		step(12);
		chk("smi_no_boundary", 1'b1, link.mgmt_active_n);
		locked_seq = 1'b1;
		instr_boundary = 1'b1;
		step(6);
		chk("smi_locked", 1'b1, link.mgmt_active_n);
		locked_seq = 1'b0;
		for (n = 0; n < 20 && link.mgmt_active_n !== 1'b0; n++) step(1);
		chk("smi_enter", 1'b0, link.mgmt_active_n);
		pulse(save_done);
		// Two nested edges; only one may be kept
		pulse(smi_fire);
		step(8);
		pulse(smi_fire);
		step(8);
		pulse(resume_from_mgmt_instr);
		step(3);
		chk("act_held", 1'b0, link.mgmt_active_n);
		pulse(restore_done);
		for (n = 0; n < 4 && link.mgmt_active_n !== 1'b1; n++) step(1);
		chk("act_release", 1'b1, link.mgmt_active_n);
		for (n = 0; n < 20 && link.mgmt_active_n !== 1'b0; n++) step(1);
		chk("nested_enter", 1'b0, link.mgmt_active_n);
		pulse(save_done);
		pulse(resume_from_mgmt_instr);
		pulse(restore_done);
		step(30);
		chk("one_nested", 1'b1, link.mgmt_active_n);
		// A repeat-string step alone is a boundary too
		instr_boundary = 1'b0;
		rep_iteration = 1'b1;
		pulse(smi_fire);
		for (n = 0; n < 20 && link.mgmt_active_n !== 1'b0; n++) step(1);
		chk("smi_rep", 1'b0, link.mgmt_active_n);
		chk("in_mgmt", 1'b1, in_mgmt);
		pulse(save_done);
		chk("sys_in_mgmt", 1'b1, cpu_in_mgmt);
		pulse(resume_from_mgmt_instr);
		pulse(restore_done);
		chk("in_mgmt_off", 1'b0, in_mgmt);
		rep_iteration = 1'b0;
		instr_boundary = 1'b1;
		$display("Test management done");
		// Grant only once the pipelines have drained
		halt_want = 1'b1;
		step(15);
		chk("halt_undrained", 1'b0, halt_granted);
		drained = 1'b1;
		for (n = 0; n < 20 && halt_granted !== 1'b1; n++) step(1);
		chk("halt_granted", 1'b1, halt_granted);
		chk("stopped", 1'b1, core_stopped);
		halt_want = 1'b0;
		for (n = 0; n < 20 && core_stopped !== 1'b0; n++) step(1);
		chk("resumed", 1'b0, core_stopped);
		// A pending NMI outranks the halt request
		pulse(nmi_fire);
		step(6);
		chk("nmi_before_halt", 1'b1, nmi_pending);
		halt_want = 1'b1;
		step(15);
		chk("halt_deferred", 1'b0, core_stopped);
		pulse(nmi_take);
		for (n = 0; n < 20 && core_stopped !== 1'b1; n++) step(1);
		chk("halt_after_nmi", 1'b1, core_stopped);
		halt_want = 1'b0;
		for (n = 0; n < 20 && core_stopped !== 1'b0; n++) step(1);
		chk("resumed_again", 1'b0, core_stopped);
		$display("Test halt done");
		// Hold waits for the running cycle, request still shown
		bus_cycle_busy = 1'b1;
		bus_req_core = 1'b1;
		hold_want = 1'b1;
		step(8);
		chk("ack_busy", 1'b0, link.bus_yield_ack);
		bus_cycle_busy = 1'b0;
		for (n = 0; n < 10 && link.bus_yield_ack !== 1'b1; n++) step(1);
		chk("float", 1'b1, link.bus_float);
		step(10);
		chk("ack_kept", 1'b1, link.bus_yield_ack);
		chk("sys_ack", 1'b1, hold_granted);
		chk("want", 1'b1, link.internal_bus_want);
		chk("sys_want", 1'b1, cpu_bus_want);
		hold_want = 1'b0;
		bus_req_core = 1'b0;
		step(6);
		chk("ack_drop", 1'b0, link.bus_yield_ack);
		chk("sys_ack_drop", 1'b0, hold_granted);
		chk("want_drop", 1'b0, link.internal_bus_want);
		$display("Test hold done");
		// Soft reset clears state but keeps the base
		base_wdata = 32'h0004_8000;
		pulse(base_we);
		pulse(nmi_fire);
		step(10);
		pulse(srst_fire);
		for (n = 0; n < 40 && soft_reset_pulse !== 1'b1; n++) step(1);
		chk("srst_pulse", 1'b1, soft_reset_pulse);
		step(25);
		chk("base_kept", 32'h0004_8000, mgmt_base_reg);
		chk("nmi_cleared", 1'b0, nmi_pending);
		$display("Test soft reset done");
		end_of_test();
	end
endmodule
